/* File: core/cct_pkg.sv */
package cct_pkg;

   localparam int NCH = 8;
   localparam int ADDR_W = 8;

   // Register indexes; byte address is four times the index
   localparam logic [5:0] IDX_MODE = 6'h00;
   localparam logic [5:0] IDX_FORCE = 6'h01;
   localparam logic [5:0] IDX_MASK = 6'h02;
   localparam logic [5:0] IDX_DATA = 6'h03;
   localparam logic [5:0] IDX_CNT_HI = 6'h04;
   localparam logic [5:0] IDX_CNT_LO = 6'h05;
   localparam logic [5:0] IDX_SYSCTL = 6'h06;
   localparam logic [5:0] IDX_ACTION = 6'h08;
   localparam logic [5:0] IDX_CHFLAG = 6'h0E;
   localparam logic [5:0] IDX_OVFLAG = 6'h0F;
   localparam logic [5:0] IDX_CH_FIRST = 6'h10;
   localparam logic [5:0] IDX_CH_LAST = 6'h1F;
   localparam logic [5:0] IDX_ACCFLAG = 6'h21;
   localparam logic [5:0] IDX_ACC_HI = 6'h22;
   localparam logic [5:0] IDX_ACC_LO = 6'h23;

   // Field positions
   localparam int SC_RUN = 7;
   localparam int SC_WAIT = 6;
   localparam int SC_FRZ = 5;
   localparam int SC_FFC = 4;
   localparam int OVF_BIT = 7;
   localparam int ACC_OVF_BIT = 1;
   localparam int ACC_IN_BIT = 0;

   // Reset values and prescaler
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_WORD = 16'h0000;
   localparam logic [5:0] PRE_LAST = 6'h3F;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      ACT_OFF = 2'b00,
      ACT_TOGGLE = 2'b01,
      ACT_LOW = 2'b10,
      ACT_HIGH = 2'b11
   } cct_act_e;

   typedef struct packed {
      logic timer_run;
      logic stop_in_wait;
      logic stop_in_freeze;
      logic fast_flag_clear;
   } cct_ctrl_s;

   localparam cct_ctrl_s RST_CTRL = '{1'b0, 1'b0, 1'b0, 1'b0};

   // Pin level after a compare action
   function automatic logic cct_apply(input logic cur, input logic [1:0] code);
      unique case (code)
         ACT_OFF: cct_apply = cur;
         ACT_TOGGLE: cct_apply = ~cur;
         ACT_LOW: cct_apply = 1'b0;
         ACT_HIGH: cct_apply = 1'b1;
      endcase
   endfunction

   // Channel register range decode
   function automatic logic cct_is_ch(input logic [5:0] idx);
      cct_is_ch = (idx >= IDX_CH_FIRST) && (idx <= IDX_CH_LAST);
   endfunction

endpackage

/* File: core/cct_count.sv */
`timescale 1ns/10ps
module cct_count (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Run controls
   input wire logic pre_run,
   input wire logic cnt_run,
   // Test mode load
   input wire logic load,
   input wire logic [15:0] load_val,
   // Results
   output logic [15:0] count,
   output logic wrap,
   output logic tick64
);

   logic [5:0] pre;

   // Prescaler keeps running across counter loads, so the first period is unaligned
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pre <= cct_pkg::PRE_LAST;
      end else if (pre_run) begin
         pre <= pre + 6'h01;
      end
   end

   // Divide-by-64 tick only while the timer is active
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tick64 <= 1'b0;
      end else begin
         tick64 <= pre_run && (pre == cct_pkg::PRE_LAST);
      end
   end

   // Up counter; a load wins over counting
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count <= cct_pkg::RST_WORD;
         wrap <= 1'b0;
      end else if (load) begin
         count <= load_val;
         wrap <= 1'b0;
      end else begin
         wrap <= cnt_run && (count == 16'hFFFF);
         if (cnt_run) begin
            count <= count + 16'h0001;
         end
      end
   end

endmodule

/* File: core/cct_top.sv */
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module cct_top (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Processor modes
   input wire logic wait_mode,
   input wire logic freeze_mode,
   input wire logic test_mode,
   // Accumulator events and clock
   input wire logic acc_overflow_evt,
   input wire logic acc_input_evt,
   output logic acc_tick64,
   output logic acc_run,
   // Channel pins
   input wire logic [7:0] pin_in,
   output logic [7:0] pin_out,
   output logic [7:0] pin_oe
);

   typedef enum logic {WR_COLLECT = 1'b0, WR_RESP = 1'b1} cct_wr_e;
   typedef enum logic {RD_IDLE = 1'b0, RD_DATA = 1'b1} cct_rd_e;

   cct_wr_e wr_state;
   cct_rd_e rd_state;
   logic aw_held, w_held;
   logic [5:0] wr_idx;
   logic [31:0] wr_data;
   logic [3:0] wr_strb;
   logic [7:0] channel_is_compare, ch7_compare_mask, ch7_compare_data;
   logic [15:0] action_codes;
   cct_pkg::cct_ctrl_s ctrl;
   logic [7:0] channel_flag;
   logic count_overflow_flag, accumulator_overflow_flag, accumulator_input_flag;
   logic [15:0] channel_compare_value [8];
   logic [7:0] pin_prev;
   logic [15:0] count;
   logic wrap, tick64;
   logic active, cnt_run, we, re;
   logic [5:0] rd_idx;
   logic [7:0] force_bit, match, capture, event_any, ch7_fire;
   logic [2:0] wr_ch, rd_ch;
   logic [15:0] next_count;
   logic [31:0] rd_word;

   ////////////////////////////////////////////////////////////////////////////
   // Register bus

   assign we = (wr_state == WR_COLLECT) && aw_held && w_held;
   assign re = s_axi_arvalid && s_axi_arready;
   assign rd_idx = s_axi_araddr[7:2];
   assign wr_ch = wr_idx[3:1];
   assign rd_ch = rd_idx[3:1];

   // Address and data are taken in either order, then one write is performed
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wr_state <= WR_COLLECT;
         aw_held <= 1'b0;
         w_held <= 1'b0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cct_pkg::RESP_OKAY;
         wr_idx <= 6'h00;
         wr_data <= 32'h00000000;
         wr_strb <= 4'h0;
      end else begin
         unique case (wr_state)
            WR_COLLECT: begin
               s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
               s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready);
               if (s_axi_awvalid && s_axi_awready) begin
                  aw_held <= 1'b1;
                  wr_idx <= s_axi_awaddr[7:2];
               end
               if (s_axi_wvalid && s_axi_wready) begin
                  w_held <= 1'b1;
                  wr_data <= s_axi_wdata;
                  wr_strb <= s_axi_wstrb;
               end
               if (we) begin
                  wr_state <= WR_RESP;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp <= map_ok(wr_idx) ? cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
               end
            end
            WR_RESP: begin
               if (s_axi_bready) begin
                  wr_state <= WR_COLLECT;
                  s_axi_bvalid <= 1'b0;
                  aw_held <= 1'b0;
                  w_held <= 1'b0;
                  s_axi_awready <= 1'b1;
                  s_axi_wready <= 1'b1;
               end
            end
         endcase
      end
   end

   // Mapped indexes; anything else answers with a slave error
   function automatic logic map_ok(input logic [5:0] idx);
      map_ok = (idx <= cct_pkg::IDX_SYSCTL) || (idx == cct_pkg::IDX_ACTION)
         || (idx == cct_pkg::IDX_CHFLAG) || (idx == cct_pkg::IDX_OVFLAG)
         || cct_pkg::cct_is_ch(idx) || (idx == cct_pkg::IDX_ACCFLAG)
         || (idx == cct_pkg::IDX_ACC_HI) || (idx == cct_pkg::IDX_ACC_LO);
   endfunction

   // Read data mux
   always_comb begin
      rd_word = 32'h00000000;
      unique case (rd_idx)
         cct_pkg::IDX_MODE: rd_word[7:0] = channel_is_compare;
         cct_pkg::IDX_FORCE: rd_word[7:0] = cct_pkg::RST_BYTE;
         cct_pkg::IDX_MASK: rd_word[7:0] = ch7_compare_mask;
         cct_pkg::IDX_DATA: rd_word[7:0] = ch7_compare_data;
         cct_pkg::IDX_CNT_HI: rd_word[15:0] = count;
         cct_pkg::IDX_CNT_LO: rd_word[7:0] = count[7:0];
         cct_pkg::IDX_SYSCTL: rd_word[7:4] = ctrl;
         cct_pkg::IDX_ACTION: rd_word[15:0] = action_codes;
         cct_pkg::IDX_CHFLAG: rd_word[7:0] = channel_flag;
         cct_pkg::IDX_OVFLAG: rd_word[cct_pkg::OVF_BIT] = count_overflow_flag;
         cct_pkg::IDX_ACCFLAG: begin
            rd_word[cct_pkg::ACC_OVF_BIT] = accumulator_overflow_flag;
            rd_word[cct_pkg::ACC_IN_BIT] = accumulator_input_flag;
         end
         default: begin
            if (cct_pkg::cct_is_ch(rd_idx)) begin
               rd_word[15:0] = channel_compare_value[rd_ch];
            end
         end
      endcase
   end

   // Read channel: one word per request, answered the cycle after the address
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rd_state <= RD_IDLE;
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= cct_pkg::RESP_OKAY;
      end else begin
         unique case (rd_state)
            RD_IDLE: begin
               s_axi_arready <= !re;
               if (re) begin
                  rd_state <= RD_DATA;
                  s_axi_rvalid <= 1'b1;
                  s_axi_rdata <= rd_word;
                  s_axi_rresp <= map_ok(rd_idx) ? cct_pkg::RESP_OKAY : cct_pkg::RESP_SLVERR;
               end
            end
            RD_DATA: begin
               if (s_axi_rready) begin
                  rd_state <= RD_IDLE;
                  s_axi_rvalid <= 1'b0;
                  s_axi_arready <= 1'b1;
               end
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control registers

   // Plain read-write control
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_is_compare <= cct_pkg::RST_BYTE;
         ch7_compare_mask <= cct_pkg::RST_BYTE;
         ch7_compare_data <= cct_pkg::RST_BYTE;
         ctrl <= cct_pkg::RST_CTRL;
         action_codes <= cct_pkg::RST_WORD;
      end else if (we && wr_strb[0]) begin
         unique case (wr_idx)
            cct_pkg::IDX_MODE: channel_is_compare <= wr_data[7:0];
            cct_pkg::IDX_MASK: ch7_compare_mask <= wr_data[7:0];
            cct_pkg::IDX_DATA: ch7_compare_data <= wr_data[7:0];
            cct_pkg::IDX_SYSCTL: ctrl <= wr_data[7:4];
            cct_pkg::IDX_ACTION: begin
               action_codes[7:0] <= wr_data[7:0];
               if (wr_strb[1]) begin
                  action_codes[15:8] <= wr_data[15:8];
               end
            end
            default: ;
         endcase
      end
   end

   // Compare values, byte lanes 0 and 1; a write never costs another channel its capture
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < cct_pkg::NCH; i++) begin
            channel_compare_value[i] <= cct_pkg::RST_WORD;
         end
      end else begin
         for (int i = 0; i < cct_pkg::NCH; i++) begin
            if (capture[i]) begin
               channel_compare_value[i] <= count;
            end
         end
         if (we && cct_pkg::cct_is_ch(wr_idx) && channel_is_compare[wr_ch]) begin
            if (wr_strb[0]) begin
               channel_compare_value[wr_ch][7:0] <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
               channel_compare_value[wr_ch][15:8] <= wr_data[15:8];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Counter

   // Wait stop halts everything; freeze stop halts the count only
   assign active = ctrl.timer_run && !(ctrl.stop_in_wait && wait_mode);
   assign cnt_run = active && !(ctrl.stop_in_freeze && freeze_mode);

   // Word write at the high index loads both bytes; low index loads one
   always_comb begin
      next_count = count;
      if (wr_idx == cct_pkg::IDX_CNT_HI) begin
         if (wr_strb[0]) begin
            next_count[7:0] = wr_data[7:0];
         end
         if (wr_strb[1]) begin
            next_count[15:8] = wr_data[15:8];
         end
      end else if (wr_strb[0]) begin
         next_count[7:0] = wr_data[7:0];
      end
   end

   cct_count u_count (
      .aclk(aclk),
      .aresetn(aresetn),
      .pre_run(active),
      .cnt_run(cnt_run),
      .load(we && test_mode && ((wr_idx == cct_pkg::IDX_CNT_HI)
         || (wr_idx == cct_pkg::IDX_CNT_LO))),
      .load_val(next_count),
      .count(count),
      .wrap(wrap),
      .tick64(tick64)
   );

   // Accumulator clock and run level, registered for clean outputs
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         acc_tick64 <= 1'b0;
         acc_run <= 1'b0;
      end else begin
         acc_tick64 <= tick64;
         acc_run <= !(ctrl.stop_in_wait && wait_mode);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Channel events

   // Forces apply to compare channels only; a match needs a moving counter
   always_comb begin
      for (int i = 0; i < cct_pkg::NCH; i++) begin
         force_bit[i] = we && wr_strb[0] && (wr_idx == cct_pkg::IDX_FORCE)
            && wr_data[i] && channel_is_compare[i];
         match[i] = cnt_run && channel_is_compare[i] && (count == channel_compare_value[i]);
         capture[i] = active && !channel_is_compare[i] && pin_in[i] && !pin_prev[i];
      end
   end
   assign event_any = match | force_bit;
   assign ch7_fire = {cct_pkg::NCH{event_any[7]}} & ch7_compare_mask & channel_is_compare;

   // Capture on rising pin edges
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_prev <= cct_pkg::RST_BYTE;
      end else begin
         pin_prev <= pin_in;
      end
   end

   // Channel 7 data overrides any local action on masked pins
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_out <= cct_pkg::RST_BYTE;
         pin_oe <= cct_pkg::RST_BYTE;
      end else begin
         for (int i = 0; i < cct_pkg::NCH; i++) begin
            pin_oe[i] <= channel_is_compare[i]
               && (ch7_compare_mask[i] || (action_codes[2*i +: 2] != cct_pkg::ACT_OFF));
            if (ch7_fire[i]) begin
               pin_out[i] <= ch7_compare_data[i];
            end else if (event_any[i]) begin
               pin_out[i] <= cct_pkg::cct_apply(pin_out[i], action_codes[2*i +: 2]);
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Flags: a set in the same cycle as a clear wins

   // Channel flags; a force masks its own match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         channel_flag <= cct_pkg::RST_BYTE;
      end else begin
         for (int i = 0; i < cct_pkg::NCH; i++) begin
            if ((match[i] && !force_bit[i]) || capture[i]) begin
               channel_flag[i] <= 1'b1;
            end else if (we && wr_strb[0] && (wr_idx == cct_pkg::IDX_CHFLAG) && wr_data[i]) begin
               channel_flag[i] <= 1'b0;
            end else if (ctrl.fast_flag_clear && (
               (re && cct_pkg::cct_is_ch(rd_idx) && rd_ch == i && !channel_is_compare[i])
               || (we && cct_pkg::cct_is_ch(wr_idx) && wr_ch == i && channel_is_compare[i]))) begin
               channel_flag[i] <= 1'b0;
            end
         end
      end
   end

   // Overflow flag
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_overflow_flag <= 1'b0;
      end else if (wrap) begin
         count_overflow_flag <= 1'b1;
      end else if (we && wr_strb[0] && (wr_idx == cct_pkg::IDX_OVFLAG)
         && wr_data[cct_pkg::OVF_BIT]) begin
         count_overflow_flag <= 1'b0;
      end else if (ctrl.fast_flag_clear && (
         (re && (rd_idx == cct_pkg::IDX_CNT_HI || rd_idx == cct_pkg::IDX_CNT_LO))
         || (we && (wr_idx == cct_pkg::IDX_CNT_HI || wr_idx == cct_pkg::IDX_CNT_LO)))) begin
         count_overflow_flag <= 1'b0;
      end
   end

   // Accumulator flags, set by the accumulator's own events
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         accumulator_overflow_flag <= 1'b0;
         accumulator_input_flag <= 1'b0;
      end else begin
         if (acc_overflow_evt) begin
            accumulator_overflow_flag <= 1'b1;
         end else if (acc_clear(cct_pkg::ACC_OVF_BIT)) begin
            accumulator_overflow_flag <= 1'b0;
         end
         if (acc_input_evt) begin
            accumulator_input_flag <= 1'b1;
         end else if (acc_clear(cct_pkg::ACC_IN_BIT)) begin
            accumulator_input_flag <= 1'b0;
         end
      end
   end

   // Write-one clear or fast clear by count access
   function automatic logic acc_clear(input int b);
      acc_clear = (we && wr_strb[0] && (wr_idx == cct_pkg::IDX_ACCFLAG) && wr_data[b])
         || (ctrl.fast_flag_clear
         && ((re && (rd_idx == cct_pkg::IDX_ACC_HI || rd_idx == cct_pkg::IDX_ACC_LO))
         || (we && (wr_idx == cct_pkg::IDX_ACC_HI || wr_idx == cct_pkg::IDX_ACC_LO))));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Assertions

   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_forced(int i);
      force_bit[i] && !ch7_fire[i];
   endsequence

   a_force_reads_zero: assert property (
      re && rd_idx == cct_pkg::IDX_FORCE |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
      else $error("force register read not zero");
   a_force_no_flag: assert property (
      force_bit[0] && !capture[0] && !channel_flag[0] |=> !channel_flag[0])
      else $error("forced compare set a flag");
   a_force_action: assert property (
      s_forced(0) && action_codes[1:0] == cct_pkg::ACT_HIGH |=> pin_out[0])
      else $error("forced drive high missing");
   a_ch7_override: assert property (
      ch7_fire[2] |=> pin_out[2] == $past(ch7_compare_data[2]))
      else $error("channel 7 data not on masked pin");
   a_mask_output: assert property (
      channel_is_compare[3] && ch7_compare_mask[3] |=> pin_oe[3])
      else $error("masked compare pin not an output");
   a_count_stop: assert property (
      !ctrl.timer_run && !we |=> $stable(count))
      else $error("counter moved while disabled");
   a_count_up: assert property (
      cnt_run && !we |=> count == $past(count) + 16'h0001)
      else $error("counter did not count up");
   a_no_tick_idle: assert property (
      !active [*3] |-> !acc_tick64)
      else $error("accumulator tick while timer inactive");
   a_write_ignored: assert property (
      we && !test_mode && !cnt_run && wr_idx == cct_pkg::IDX_CNT_HI |=> $stable(count))
      else $error("counter written outside test mode");
   a_ovf_fast: assert property (
      ctrl.fast_flag_clear && re && rd_idx == cct_pkg::IDX_CNT_HI && !wrap
      |=> !count_overflow_flag)
      else $error("fast clear missed overflow flag");
   a_bus_answer: assert property (
      re |=> s_axi_rvalid)
      else $error("read not answered in one cycle");

endmodule

/* File: dv/cct_pin_partner.sv */
`timescale 1ns/10ps
module cct_pin_partner (
   // Block side of the pins
   input wire logic [7:0] pin_out,
   input wire logic [7:0] pin_oe,
   // Outside source when the block lets go
   input wire logic [7:0] ext,
   output logic [7:0] pin_in
);
   // The block owns a pin only while it enables it, else the outside level shows
   assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext);
endmodule

/* File: dv/test_capture_compare_timer_control.sv */
`timescale 1ns/10ps
module test_capture_compare_timer_control;
   logic aclk, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, wait_mode = 0, freeze_mode = 0;
   logic test_mode = 0, acc_overflow_evt = 0, acc_input_evt = 0;
   logic [7:0] ext = 0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic acc_tick64, acc_run;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0, pin_in, pin_out, pin_oe, m, d, po;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, r;
   logic [3:0] s_axi_wstrb = 4'hF;
   logic [1:0] s_axi_bresp, s_axi_rresp, code;
   logic [33:0] expq[$];
   int num_errors = 0, n_checks = 0, ticks = 0;
   cct_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
      .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .wait_mode,
      .freeze_mode, .test_mode, .acc_overflow_evt, .acc_input_evt, .acc_tick64,
      .acc_run, .pin_in, .pin_out, .pin_oe);
   cct_pin_partner far_end (.pin_out, .pin_oe, .ext(ext), .pin_in);
   ////////////////////////////////////////////////////////////////////////////
   // Clock and the divide-by-64 tick tally
   initial begin
      aclk = 0;
      forever #12.5 aclk = ~aclk;
   end
   always @(posedge aclk) if (acc_tick64) ticks++;
   // Compare one result with its note
   task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
      n_checks++;
      if (g !== e) begin
         num_errors++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   // Every read answer takes the oldest note off the queue
   always @(posedge aclk) if (s_axi_rvalid && s_axi_rready)
      chk("rdata", expq.pop_front(), {s_axi_rresp, s_axi_rdata});
   ////////////////////////////////////////////////////////////////////////////
   // Write: address and data offered together, each dropped when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      chk("bresp", {32'h0, er}, {32'h0, s_axi_bresp});
      s_axi_bready <= 0;
   endtask
   // Read: the expected word is noted before the request goes out
   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      expq.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
   endtask
   // Pins lag a force write by one registered cycle; enables lag a control register write by two
   task automatic pins(input logic [15:0] e);
      repeat (2) @(posedge aclk);
      chk("pins", {18'h0, e}, {18'h0, pin_oe, pin_out});
   endtask
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      num_errors++;
      wrap_up;
   end
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      void'($urandom(77176));
      repeat (6) @(posedge aclk);
      aresetn <= 1;
      rd(8'h00, 34'h0);
      wr(8'h00, 32'hFF);
      rd(8'h00, 34'hFF);
      wr(8'h04, 32'hFF);
      rd(8'h04, 34'h0);
      rd(8'h1C, {2'h2, 32'h0});
      wr(8'h1C, 32'h5A, 2'h2);
      // Random mask and data; channel 7 forced, mask kept off bit 7
      r = $urandom;
      m = {1'b0, r[6:0]};
      d = r[15:8];
      wr(8'h0C, {24'h0, d});
      wr(8'h08, {24'h0, m});
      wr(8'h04, 32'h80);
      pins({m, m & d});
      wr(8'h08, 32'h0);
      po = m & d;
      // Every action code on channel 0, ending with the disconnect code
      for (int c = 1; c < 5; c++) begin
         code = c[1:0];
         wr(8'h20, {30'h0, code});
         wr(8'h04, 32'h01);
         po[0] = (code == 2'h1) ? ~po[0] : (code == 2'h0) ? po[0] : code[0];
         pins({7'h0, code != 2'h0, po});
      end
      // Wrap the counter to raise the overflow flag
      test_mode <= 1;
      wr(8'h10, 32'hFFF0);
      wr(8'h18, 32'h80);
      repeat (40) @(posedge aclk);
      rd(8'h3C, 34'h80);
      wr(8'h18, 32'h0);
      wr(8'h10, 32'h5);
      rd(8'h10, 34'h5);
      rd(8'h3C, 34'h80);
      wr(8'h18, 32'h10);
      rd(8'h10, 34'h5);
      rd(8'h3C, 34'h0);
      @(posedge aclk);
      acc_overflow_evt <= 1;
      acc_input_evt <= 1;
      @(posedge aclk);
      acc_overflow_evt <= 0;
      acc_input_evt <= 0;
      rd(8'h84, 34'h3);
      rd(8'h88, 34'h0);
      rd(8'h84, 34'h0);
      // Freeze holds only the counter; wait holds all of it
      freeze_mode <= 1;
      wr(8'h18, 32'hA0);
      ticks = 0;
      wr(8'h10, 32'h1234);
      repeat (70) @(posedge aclk);
      rd(8'h10, 34'h1234);
      chk("acc_run", 34'h1, {33'h0, acc_run});
      chk("ticks", 34'h1, {33'h0, ticks != 0});
      test_mode <= 0;
      wr(8'h10, 32'hBEEF);
      rd(8'h10, 34'h1234);
      wait_mode <= 1;
      wr(8'h18, 32'hE0);
      freeze_mode <= 0;
      // A tick launched just before the stop still needs two flops to drain
      repeat (3) @(posedge aclk);
      ticks = 0;
      repeat (70) @(posedge aclk);
      rd(8'h10, 34'h1234);
      chk("acc_run", 34'h0, {33'h0, acc_run});
      chk("ticks", 34'h0, 34'(ticks));
      // Capture on channel 1 with the count frozen, then fast clear by reading it
      wait_mode <= 0;
      freeze_mode <= 1;
      wr(8'h18, 32'hB0);
      wr(8'h00, 32'hFD);
      wr(8'h38, 32'hFF);
      rd(8'h38, 34'h0);
      ext <= 8'h02;
      rd(8'h38, 34'h2);
      rd(8'h48, 34'h1234);
      rd(8'h38, 34'h0);
      wrap_up;
   end
endmodule
